// File: design/ibc_consts.svh
// ibc_consts.svh: offsets-free constants of the bus condition and acknowledge block
// assumes it is included by bare name from the design files
// Summary of operation
// RULE1: As master, start on begin request or buffer write, picked by the bypass bit.
// RULE2: Master start waits until the bus-idle flag is set.
// RULE3: Bus-idle flag sets after both lines stay high for the selected cycle count.
// RULE4: Any start condition on the bus clears the bus-idle flag.
// RULE5: Simultaneous starts are no collision; address phase arbitration settles ownership.
// RULE6: Ninth clock is the acknowledge slot; transmitter releases, receiver drives or releases.
// RULE7: While byte count is non-zero, answer with the mid-count acknowledge value.
// RULE8: As slave, hold clock low after address or eighth fall when hold enabled.
// RULE9: When byte count is zero, answer with the end-of-count acknowledge value.
// RULE10: As transmitter, store the receiver answer: clear on ACK, set on NACK.
// RULE11: Acknowledge-phase flag sets at eighth falling edge, clears at ninth rising edge.
// RULE12: Any of the four buffer error flags forces a NACK answer.
// RULE13: After a NACK on the bus, answer NACK until errors are cleared.
// RULE14: A restart resets slave logic exactly like a start, ready for an address.
// RULE15: Masters put the direction bit in the address LSB; set means read.
// RULE16: Ten-bit reads use restart plus upper byte with read bit; slave then transmits.
// RULE17: Master sends stop on NACK, time-out, or byte count reaching zero.
// RULE18: Time-out source picked by select; expiry resets the logic and forces idle.
// RULE19: Slave time-out resets at once, clears slave-active and clock hold, sets flag.
// RULE20: Master time-out sets event flag and sends stop, deferred while clock held.
// RULE21: Master-active stays set after time-out until the stop appears on the bus.
// RULE22: Data changes only while clock is low; sampled on clock rising edge.
// RULE23: Byte count decrements once per data byte transferred.
`ifndef IBC_CONSTS_SVH
`define IBC_CONSTS_SVH

// bus clocks per scl half period, minus one at the end count
`define IBC_HALF_END 4'h3
// idle-time thresholds in bus clocks
`define IBC_IDLE0 8'h08
`define IBC_IDLE1 8'h10
`define IBC_IDLE2 8'h20
`define IBC_IDLE3 8'h40
// acknowledge levels and byte framing
`define IBC_ACK 1'b0
`define IBC_NACK 1'b1
`define IBC_LAST_BIT 4'h8
`define IBC_CNT_ZERO 8'h00

`endif

// File: design/ibc_pkg.sv
// ibc_pkg.sv: types of the bus condition and acknowledge block
// assumes nothing beyond a SystemVerilog compiler
package ibc_pkg;

  typedef struct packed {
    logic address_buffer_bypass;
    logic [1:0] idle_time_select;
    logic midcount_ack_value;
    logic endcount_ack_value;
    logic address_hold_enable;
    logic write_hold_enable;
    logic [1:0] timeout_source_select;
  } ibc_cfg_s;

  typedef struct packed {
    logic transmit_write_error;
    logic transmit_underflow;
    logic receive_read_error;
    logic receive_overflow;
  } ibc_err_s;

  typedef struct packed {
    logic bus_idle_flag;
    logic ack_phase_flag;
    logic received_ack_status;
    logic slave_active_flag;
    logic master_active_flag;
    logic clock_hold_flag;
    logic byte_count_zero;
  } ibc_stat_s;

  typedef enum logic [2:0] {
    ms_idle,
    ms_wait,
    ms_start,
    ms_low,
    ms_high,
    ms_stop_low,
    ms_stop_high
  } ibc_mst_e;

endpackage

// File: design/ibc_top.sv
// ibc_top.sv: start, acknowledge, stop and time-out logic of a two-wire bus controller
// assumes pads resolve open-drain levels outside; software side runs on sys_clk
`timescale 1ns/1ns
`default_nettype none
`include "ibc_consts.svh"

module ibc_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bus_clk,
  input wire ibc_pkg::ibc_cfg_s cfg,
  input wire ibc_pkg::ibc_err_s err,
  input wire logic begin_request,
  input wire logic txb_write,
  input wire logic [7:0] transmit_holding_buffer,
  input wire logic count_load,
  input wire logic [7:0] count_value,
  input wire logic hold_release,
  input wire logic [3:0] timeout_sources,
  input wire logic timeout_flag_clear,
  input wire logic slave_addressed,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output var ibc_pkg::ibc_stat_s status,
  output logic timeout_event_flag
);
  import ibc_pkg::*;

  // RULE9 end-count value once the count is zero
  function automatic logic ack_bit(input logic zero, input logic mid,
                                   input logic endc, input logic forced);
    ack_bit = forced ? `IBC_NACK : (zero ? endc : mid);
  endfunction

  // ************************************************
  // software side
  // ************************************************
  // toggles: 0 start, 1 release, 2 count, 3 timeout, 4 buffer
  logic [4:0] tg_sys_r;
  logic [7:0] tx_hold_r;
  logic [7:0] cnt_hold_r;
  logic tmo_flag_r;
  ibc_stat_s st_s0_r;
  ibc_stat_s status_r;
  ibc_stat_s stat_r;
  wire start_req;
  wire tmo_hit;
  wire tmo_act;

  // RULE1 start source select
  assign start_req = cfg.address_buffer_bypass ? txb_write : begin_request;
  // RULE18 time-out source select
  assign tmo_hit = timeout_sources[cfg.timeout_source_select];
  assign tmo_act = tmo_hit & (status_r.slave_active_flag | status_r.master_active_flag);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tg_sys_r <= 5'h00;
      tx_hold_r <= 8'h00;
      cnt_hold_r <= 8'h00;
      tmo_flag_r <= 1'b0;
      st_s0_r <= '0;
      status_r <= '0;
    end else begin
      tg_sys_r <= tg_sys_r ^ {txb_write, tmo_act, count_load, hold_release, start_req};
      if (txb_write) tx_hold_r <= transmit_holding_buffer;
      if (count_load) cnt_hold_r <= count_value;
      // RULE19 event flag, set beats clear
      tmo_flag_r <= tmo_act | (tmo_flag_r & ~timeout_flag_clear);
      st_s0_r <= stat_r;
      status_r <= st_s0_r;
    end
  end

  assign status = status_r;
  assign timeout_event_flag = tmo_flag_r;

  // ************************************************
  // crossings into the bus domain
  // ************************************************
  logic [1:0] brst_s;
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic [4:0] tg_s0;
  logic [4:0] tg_s1;
  logic [4:0] tg_s2;
  ibc_cfg_s cfg_s0;
  ibc_cfg_s cfg_b;
  ibc_err_s err_s0;
  ibc_err_s err_b;
  logic scl_q;
  logic sda_q;
  wire brst;
  wire scl_now;
  wire sda_now;
  wire [4:0] evt;

  always_ff @(posedge bus_clk) begin
    brst_s <= {brst_s[0], rst};
    scl_s <= {scl_s[0], scl_in};
    sda_s <= {sda_s[0], sda_in};
  end

  assign brst = brst_s[1];
  assign scl_now = scl_s[1];
  assign sda_now = sda_s[1];

  always_ff @(posedge bus_clk) begin
    if (brst) begin
      tg_s0 <= 5'h00;
      tg_s1 <= 5'h00;
      tg_s2 <= 5'h00;
      cfg_s0 <= '0;
      cfg_b <= '0;
      err_s0 <= '0;
      err_b <= '0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      tg_s0 <= tg_sys_r;
      tg_s1 <= tg_s0;
      tg_s2 <= tg_s1;
      cfg_s0 <= cfg;
      cfg_b <= cfg_s0;
      err_s0 <= err;
      err_b <= err_s0;
      scl_q <= scl_now;
      sda_q <= sda_now;
    end
  end

  assign evt = tg_s1 ^ tg_s2;

  // ************************************************
  // bus conditions and byte framing
  // ************************************************
  logic [7:0] idle_cnt_r;
  logic idle_r;
  logic [3:0] bcnt_r;
  logic ackph_r;
  logic [7:0] shift_r;
  logic first_r;
  logic sact_r;
  logic stx_r;
  logic hold_r;
  logic rack_r;
  logic nack_r;
  logic slv_ack_r;
  logic [7:0] cnt_r;
  logic [7:0] tx_b_r;
  logic mact_r;
  logic mread_r;
  logic mfirst_r;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire ack_rise;
  wire ack_fall;
  wire err_any;
  wire ack_val;
  wire slv_cond;
  wire hold_cond;
  wire mwr;
  wire [7:0] idle_lim;

  assign scl_rise = scl_now & ~scl_q;
  assign scl_fall = ~scl_now & scl_q;
  // RULE22 data edges while clock is high are conditions
  assign start_det = scl_now & scl_q & sda_q & ~sda_now;
  assign stop_det = scl_now & scl_q & ~sda_q & sda_now;
  assign ack_rise = scl_rise & (bcnt_r == `IBC_LAST_BIT);
  assign ack_fall = scl_fall & (bcnt_r == `IBC_LAST_BIT);
  assign err_any = |err_b;
  // RULE12 errors force nack
  assign ack_val = ack_bit(cnt_r == `IBC_CNT_ZERO, cfg_b.midcount_ack_value,
                           cfg_b.endcount_ack_value, err_any | nack_r);
  assign slv_cond = ~mact_r & ((first_r & slave_addressed) | (sact_r & ~stx_r & ~first_r));
  assign hold_cond = ~mact_r & ((first_r & slave_addressed & cfg_b.address_hold_enable) |
                                (sact_r & ~stx_r & ~first_r & cfg_b.write_hold_enable));
  assign mwr = mfirst_r | ~mread_r;
  assign idle_lim = (cfg_b.idle_time_select == 2'h0) ? `IBC_IDLE0 :
                    (cfg_b.idle_time_select == 2'h1) ? `IBC_IDLE1 :
                    (cfg_b.idle_time_select == 2'h2) ? `IBC_IDLE2 : `IBC_IDLE3;

  always_ff @(posedge bus_clk) begin
    if (brst) begin
      idle_cnt_r <= 8'h00;
      idle_r <= 1'b0;
    end else begin
      if (~scl_now | ~sda_now) idle_cnt_r <= 8'h00;
      else if (idle_cnt_r != idle_lim) idle_cnt_r <= idle_cnt_r + 8'h01;
      // RULE4 start clears idle
      if (start_det) idle_r <= 1'b0;
      // RULE18 expiry forces idle
      else if (evt[3]) idle_r <= 1'b1;
      // RULE3 idle after selected high time
      else if (idle_cnt_r == idle_lim) idle_r <= 1'b1;
    end
  end

  always_ff @(posedge bus_clk) begin
    if (brst) begin
      bcnt_r <= 4'h0;
      ackph_r <= 1'b0;
      shift_r <= 8'h00;
      first_r <= 1'b0;
      sact_r <= 1'b0;
      stx_r <= 1'b0;
      hold_r <= 1'b0;
      rack_r <= 1'b0;
      nack_r <= 1'b0;
      slv_ack_r <= 1'b0;
      cnt_r <= 8'h00;
      tx_b_r <= 8'h00;
    end else begin
      if (evt[4]) tx_b_r <= tx_hold_r;
      // RULE14 restart resets slave like a start
      if (start_det) begin
        bcnt_r <= 4'h0;
        ackph_r <= 1'b0;
        first_r <= 1'b1;
        sact_r <= 1'b0;
        stx_r <= 1'b0;
        hold_r <= 1'b0;
        slv_ack_r <= 1'b0;
        if (~err_any) nack_r <= 1'b0;
      end else if (evt[3] & sact_r) begin
        // RULE19 slave time-out reset
        bcnt_r <= 4'h0;
        ackph_r <= 1'b0;
        first_r <= 1'b0;
        sact_r <= 1'b0;
        hold_r <= 1'b0;
        slv_ack_r <= 1'b0;
      end else begin
        if (ack_rise) begin
          // RULE11 ack phase ends at ninth rise
          bcnt_r <= 4'h0;
          ackph_r <= 1'b0;
          first_r <= 1'b0;
          // RULE10 transmitter records answer
          if ((mact_r & mwr) | (sact_r & stx_r)) rack_r <= sda_now;
          // RULE13 nack seen sticks
          if (sda_now & (sact_r | mact_r)) nack_r <= 1'b1;
          // RULE23 one decrement per data byte
          if (~first_r & (sact_r | mact_r) & (cnt_r != `IBC_CNT_ZERO)) cnt_r <= cnt_r - 8'h01;
          // RULE16 direction from address LSB sets slave role
          if (first_r & slave_addressed & ~mact_r) begin
            sact_r <= 1'b1;
            stx_r <= shift_r[0];
          end
        end else if (scl_rise) begin
          bcnt_r <= bcnt_r + 4'h1;
          shift_r <= {shift_r[6:0], sda_now};
        end
        // RULE11 ack phase starts at eighth fall
        if (ack_fall) ackph_r <= 1'b1;
        // RULE8 stretch until software answers
        if (ack_fall & hold_cond) hold_r <= 1'b1;
        else if (evt[1]) hold_r <= 1'b0;
        // RULE6 receiver ack changes only while clock low
        if (scl_fall & ~ackph_r & ~ack_fall) slv_ack_r <= 1'b0;
        else if (ackph_r & ~scl_now) slv_ack_r <= slv_cond & (ack_val == `IBC_ACK);
        if (evt[2]) cnt_r <= cnt_hold_r;
      end
    end
  end

  // ************************************************
  // master sequencer
  // ************************************************
  ibc_mst_e mst_r;
  logic [3:0] mdiv_r;
  logic [3:0] mbit_r;
  logic [7:0] mbyte_r;
  logic mscl_r;
  logic msda_r;
  logic spend_r;
  wire mdiv_end;
  wire arb_lost;
  wire in_stop;

  assign mdiv_end = (mdiv_r == `IBC_HALF_END);
  assign arb_lost = scl_now & mwr & ~msda_r & ~sda_now & (mbit_r != `IBC_LAST_BIT);
  assign in_stop = (mst_r == ms_stop_low) | (mst_r == ms_stop_high);

  always_ff @(posedge bus_clk) begin
    if (brst) begin
      mst_r <= ms_idle;
      mdiv_r <= 4'h0;
      mbit_r <= 4'h0;
      mbyte_r <= 8'h00;
      mscl_r <= 1'b0;
      msda_r <= 1'b0;
      spend_r <= 1'b0;
      mact_r <= 1'b0;
      mread_r <= 1'b0;
      mfirst_r <= 1'b0;
    end else begin
      // RULE1 start requests only taken while master idle
      if (evt[0] & ~mact_r) spend_r <= 1'b1;
      // RULE21 master-active ends with the stop on the bus
      if (stop_det & (mst_r == ms_idle)) mact_r <= 1'b0;
      if (evt[3] & mact_r & ~in_stop) begin
        // RULE20 time-out forces a stop
        mst_r <= ms_stop_low;
        mdiv_r <= 4'h0;
        mscl_r <= 1'b1;
      end else begin
        unique case (mst_r)
          ms_idle: begin
            if (spend_r & ~mact_r) mst_r <= ms_wait;
          end
          ms_wait: begin
            // RULE2 wait for a free bus
            if (idle_r) begin
              mst_r <= ms_start;
              spend_r <= 1'b0;
              mact_r <= 1'b1;
              msda_r <= 1'b1;
              mdiv_r <= 4'h0;
            end
          end
          ms_start: begin
            // RULE5 a start seen here is no collision
            mdiv_r <= mdiv_r + 4'h1;
            if (mdiv_end) begin
              mst_r <= ms_low;
              mdiv_r <= 4'h0;
              mscl_r <= 1'b1;
              mbit_r <= 4'h0;
              mbyte_r <= tx_b_r;
              mread_r <= tx_b_r[0];
              mfirst_r <= 1'b1;
            end
          end
          ms_low: begin
            mdiv_r <= mdiv_r + 4'h1;
            // RULE22 data changes while clock low
            if (mdiv_r == 4'h1) begin
              // RULE7 ack value while count non-zero
              if (mbit_r == `IBC_LAST_BIT) msda_r <= ~mwr & (ack_val == `IBC_ACK);
              else msda_r <= mwr & ~mbyte_r[7];
            end
            if (mdiv_end) begin
              mst_r <= ms_high;
              mdiv_r <= 4'h0;
              mscl_r <= 1'b0;
            end
          end
          ms_high: begin
            if (scl_now) mdiv_r <= mdiv_r + 4'h1;
            // RULE5 ownership settled by arbitration
            if (arb_lost) begin
              mst_r <= ms_idle;
              mact_r <= 1'b0;
              msda_r <= 1'b0;
              mdiv_r <= 4'h0;
            end else if (mdiv_end & scl_now) begin
              mscl_r <= 1'b1;
              mdiv_r <= 4'h0;
              if (mbit_r == `IBC_LAST_BIT) begin
                mbit_r <= 4'h0;
                mfirst_r <= 1'b0;
                mbyte_r <= tx_b_r;
                // RULE17 stop on nack or zero count
                if ((mwr & sda_now) | (cnt_r == `IBC_CNT_ZERO)) mst_r <= ms_stop_low;
                else mst_r <= ms_low;
              end else begin
                mbit_r <= mbit_r + 4'h1;
                mbyte_r <= {mbyte_r[6:0], 1'b0};
                mst_r <= ms_low;
              end
            end
          end
          ms_stop_low: begin
            mdiv_r <= mdiv_r + 4'h1;
            if (mdiv_r == 4'h1) msda_r <= 1'b1;
            if (mdiv_end) begin
              mst_r <= ms_stop_high;
              mdiv_r <= 4'h0;
              mscl_r <= 1'b0;
            end
          end
          ms_stop_high: begin
            // RULE20 stop deferred while clock held
            if (scl_now) mdiv_r <= mdiv_r + 4'h1;
            if (mdiv_end & scl_now) begin
              mst_r <= ms_idle;
              mdiv_r <= 4'h0;
              msda_r <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // ************************************************
  // pins and status
  // ************************************************
  always_ff @(posedge bus_clk) begin
    if (brst) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      stat_r <= '0;
    end else begin
      scl_oe <= mscl_r | hold_r;
      sda_oe <= msda_r | slv_ack_r;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      stat_r <= '{bus_idle_flag: idle_r, ack_phase_flag: ackph_r,
                  received_ack_status: rack_r, slave_active_flag: sact_r,
                  master_active_flag: mact_r, clock_hold_flag: hold_r,
                  byte_count_zero: (cnt_r == `IBC_CNT_ZERO)};
    end
  end

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge bus_clk); endclocking
  default disable iff (brst);

  property p_start_idle;
    (mst_r == ms_start) && ($past(mst_r) == ms_wait) |-> $past(idle_r);
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("start without idle"); // RULE2

  property p_idle_high;
    $rose(idle_r) && !$past(evt[3]) |-> $past(scl_now) && $past(sda_now);
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle while line low"); // RULE3

  property p_start_busy;
    start_det |=> !idle_r;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("idle kept after start"); // RULE4

  property p_ackph_set;
    ack_fall && !start_det && !(evt[3] && sact_r) |=> ackph_r;
  endproperty
  a_ackph_set: assert property (p_ackph_set) else $error("ack phase not set"); // RULE11

  property p_ackph_clr;
    ack_rise && !(evt[3] && sact_r) |=> !ackph_r && (bcnt_r == 4'h0);
  endproperty
  a_ackph_clr: assert property (p_ackph_clr) else $error("ack phase not cleared"); // RULE11

  property p_forced;
    err_any || nack_r |-> ack_val == `IBC_NACK;
  endproperty
  a_forced: assert property (p_forced) else $error("no forced nack"); // RULE12

  property p_endcnt;
    !err_any && !nack_r && (cnt_r == `IBC_CNT_ZERO) |-> ack_val == cfg_b.endcount_ack_value;
  endproperty
  a_endcnt: assert property (p_endcnt) else $error("wrong end-count ack"); // RULE9

  property p_hold_pin;
    hold_r |=> scl_oe;
  endproperty
  a_hold_pin: assert property (p_hold_pin) else $error("hold not on pin"); // RULE8

  property p_tmo_slave;
    evt[3] && sact_r && !start_det |=> !sact_r && !hold_r;
  endproperty
  a_tmo_slave: assert property (p_tmo_slave) else $error("slave not reset"); // RULE19

  property p_mact_stop;
    $fell(mact_r) && ($past(mst_r) != ms_high) |-> $past(stop_det);
  endproperty
  a_mact_stop: assert property (p_mact_stop) else $error("active cleared early"); // RULE21

  property p_tmo_flag;
    @(posedge sys_clk) disable iff (rst) tmo_act |=> tmo_flag_r;
  endproperty
  a_tmo_flag: assert property (p_tmo_flag) else $error("time-out flag lost"); // RULE20

  c_master_start: cover property (mst_r == ms_wait ##[1:200] mst_r == ms_start);
  c_ack_phase: cover property (ack_fall ##[1:100] ack_rise);
  c_slave_hold: cover property ($rose(hold_r));
  c_tmo_stop: cover property (evt[3] && mact_r);

endmodule // ibc_top

`default_nettype wire

// File: dv/ibc_far_end.sv
// ibc_far_end.sv: far side of the two-wire bus, an acknowledging slave and a master
// assumes the bench resolves both open-drain lines with pull-ups
`timescale 1ns/1ns
`default_nettype none
module ibc_far_end #(
  parameter int HALF = 8
) (
  input wire logic bus_clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  input wire logic hold_scl,
  output logic scl_pull,
  output logic sda_pull
);
  // ****
  // slave and master behaviour
  // ****
  logic m_scl = 1'b0;
  logic m_sda = 1'b0;
  logic s_sda = 1'b0;
  logic smp = 1'b1;
  int bits = 0;
  logic [7:0] rx = 8'h00;
  logic [7:0] rxq[$];
  assign scl_pull = m_scl | hold_scl;
  assign sda_pull = m_sda | s_sda;
  // any start opens a new byte
  always @(negedge sda) if (scl === 1'b1) bits = 0;
  always @(posedge scl) begin
    if (bits < 8) rx = {rx[6:0], sda};
    bits = (bits == 8) ? 0 : bits + 1;
    if (bits == 8) rxq.push_back(rx);
  end
  // receiver pulls sda in the ack slot, changed with scl low
  always @(negedge scl) begin
    @(negedge bus_clk);
    s_sda = (bits == 8) && ack_en;
  end
  task automatic half();
    repeat (HALF) @(negedge bus_clk);
  endtask
  // clock pulse that waits out stretching, sda sampled at the rise
  task automatic pulse_scl();
    half();
    m_scl = 1'b0;
    while (scl !== 1'b1) @(negedge bus_clk);
    smp = sda;
    half();
    m_scl = 1'b1;
    @(negedge bus_clk);
  endtask
  // start or restart: sda falls while scl is high
  task automatic mstart();
    m_sda = 1'b0;
    half();
    m_scl = 1'b0;
    while (scl !== 1'b1) @(negedge bus_clk);
    half();
    m_sda = 1'b1;
    half();
    m_scl = 1'b1;
  endtask
  // transmitter releases sda for the ack slot
  task automatic mbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      m_sda = ~b[i];
      pulse_scl();
    end
    m_sda = 1'b0;
    pulse_scl();
    ack = smp;
  endtask
  task automatic mstop();
    m_sda = 1'b1;
    half();
    m_scl = 1'b0;
    while (scl !== 1'b1) @(negedge bus_clk);
    half();
    m_sda = 1'b0;
    half();
  endtask
endmodule // ibc_far_end
`default_nettype wire

// File: dv/i2c_bus_conditions_ack_timeout_test.sv
// i2c_bus_conditions_ack_timeout_test.sv: self-checking bench of ibc_top
// assumes ibc_pkg compiled first and ibc_far_end on the far side of the bus
`timescale 1ns/1ns
`default_nettype none
module i2c_bus_conditions_ack_timeout_test;
  import ibc_pkg::*;
  // ****
  // bench
  // ****
  localparam logic [4:0] CASES [5] = '{5'h0c, 5'h15, 5'h10, 5'h09, 5'h07};
  logic sys_clk = 1'b0;
  logic bus_clk = 1'b0;
  logic rst = 1'b1;
  ibc_cfg_s cfg = '0;
  ibc_err_s err = '0;
  logic txb_write = 1'b0;
  logic begin_request = 1'b0;
  logic [1:0] outs;
  logic [7:0] txb = 8'h00;
  logic count_load = 1'b0;
  logic hold_release = 1'b0;
  logic [3:0] timeout_sources = 4'h0;
  logic timeout_flag_clear = 1'b0;
  logic slave_addressed = 1'b0;
  logic ack_en = 1'b0;
  logic hold_scl = 1'b0;
  logic scl_oe;
  logic sda_oe;
  logic p_scl;
  logic p_sda;
  logic timeout_event_flag;
  ibc_stat_s status;
  int miscompares = 0;
  int checks = 0;
  int stops = 0;
  wire logic scl_w = ~(scl_oe | p_scl);
  wire logic sda_w = ~(sda_oe | p_sda);
  ibc_top dut (.sys_clk(sys_clk), .rst(rst), .bus_clk(bus_clk), .cfg(cfg), .err(err),
    .begin_request(begin_request), .txb_write(txb_write), .transmit_holding_buffer(txb),
    .count_load(count_load), .count_value(txb), .hold_release(hold_release),
    .timeout_sources(timeout_sources), .timeout_flag_clear(timeout_flag_clear),
    .slave_addressed(slave_addressed), .scl_in(scl_w), .sda_in(sda_w), .scl_out(outs[1]),
    .scl_oe(scl_oe), .sda_out(outs[0]), .sda_oe(sda_oe), .status(status),
    .timeout_event_flag(timeout_event_flag));
  ibc_far_end p (.bus_clk(bus_clk), .scl(scl_w), .sda(sda_w), .ack_en(ack_en),
    .hold_scl(hold_scl), .scl_pull(p_scl), .sda_pull(p_sda));
  initial forever #5 sys_clk = ~sys_clk;
  initial begin
    #3;
    forever begin
      #7 bus_clk = 1'b1;
      #8 bus_clk = 1'b0;
    end
  end
  always @(posedge sda_w) if (!rst && scl_w === 1'b1) stops++;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    #1;
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(input int k, input logic [7:0] v);
    @(negedge sys_clk);
    case (k)
      1: txb_write = 1'b1;
      2: count_load = 1'b1;
      3: hold_release = 1'b1;
      4: timeout_flag_clear = 1'b1;
      6: begin_request = 1'b1;
      default: timeout_sources = v[3:0];
    endcase
    txb = v;
    @(negedge sys_clk);
    {begin_request, txb_write, count_load, hold_release, timeout_flag_clear} = 5'h00;
    timeout_sources = 4'h0;
  endtask
  task automatic wait_stop(input int n);
    for (int i = 0; i < 5000 && stops == n; i++) @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
  endtask
  task automatic end_sim();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog well beyond the roughly 3200 sys_clk cycles the tests need
  initial begin
    #400000;
    miscompares++;
    end_sim();
  end
  initial begin
    logic ack;
    int n;
    cfg.idle_time_select = 2'h1;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    check(status.bus_idle_flag, 1'b0);
    repeat (60) @(posedge sys_clk);
    check(status.bus_idle_flag, 1'b1);
    $display("test idle done");
    slave_addressed = 1'b1;
    for (int k = 0; k < 5; k++) begin
      @(negedge sys_clk);
      cfg.midcount_ack_value = CASES[k][4];
      cfg.endcount_ack_value = CASES[k][3];
      err.receive_overflow = CASES[k][1];
      pulse(2, CASES[k][2] ? 8'h02 : 8'h00);
      p.mstart();
      if (k == 0) check(status.bus_idle_flag, 1'b0);
      p.mbyte(8'ha0, ack);
      check(ack, CASES[k][0]);
    end
    @(negedge sys_clk);
    err.receive_overflow = 1'b0;
    cfg.midcount_ack_value = 1'b0;
    cfg.address_hold_enable = 1'b1;
    cfg.timeout_source_select = 2'h1;
    pulse(2, 8'h02);
    p.mstart();
    fork
      p.mbyte(8'ha0, ack);
      begin
        for (int i = 0; i < 3000 && status.clock_hold_flag !== 1'b1; i++) @(posedge sys_clk);
        check(status.ack_phase_flag, 1'b1);
        check(scl_w, 1'b0);
        check({scl_oe, outs}, 8'h04);
        pulse(3, 8'h00);
      end
    join
    check(ack, 1'b0);
    repeat (10) @(posedge sys_clk);
    check(status.slave_active_flag, 1'b1);
    @(negedge sys_clk);
    cfg.write_hold_enable = 1'b1;
    fork
      p.mbyte(8'h55, ack);
      begin
        for (int i = 0; i < 3000 && status.clock_hold_flag !== 1'b1; i++) @(posedge sys_clk);
        check(status.clock_hold_flag, 1'b1);
        pulse(5, 8'h01);
        repeat (10) @(posedge sys_clk);
        check(timeout_event_flag, 1'b0);
        pulse(5, 8'h02);
        repeat (20) @(posedge sys_clk);
        check(timeout_event_flag, 1'b1);
        check(status.slave_active_flag, 1'b0);
        check(status.clock_hold_flag, 1'b0);
      end
    join
    check(ack, 1'b1);
    pulse(4, 8'h00);
    repeat (4) @(posedge sys_clk);
    check(timeout_event_flag, 1'b0);
    p.mstop();
    $display("test slave done");
    @(negedge sys_clk);
    slave_addressed = 1'b0;
    cfg.address_hold_enable = 1'b0;
    cfg.write_hold_enable = 1'b0;
    cfg.address_buffer_bypass = 1'b1;
    repeat (60) @(posedge sys_clk);
    p.mstart();
    pulse(2, 8'h01);
    pulse(1, 8'ha4);
    repeat (40) @(posedge bus_clk);
    check(sda_oe, 1'b0);
    p.mbyte(8'h30, ack);
    p.mstop();
    p.rxq.delete();
    n = stops;
    ack_en = 1'b1;
    for (int i = 0; i < 3000 && p.bits != 4; i++) @(posedge bus_clk);
    pulse(1, 8'h3c);
    wait_stop(n);
    check(8'(p.rxq.size()), 8'h02);
    check(p.rxq[0], 8'ha4);
    check(p.rxq[1], 8'h3c);
    check(status.received_ack_status, 1'b0);
    check(status.master_active_flag, 1'b0);
    check(status.byte_count_zero, 1'b1);
    $display("test master write done");
    ack_en = 1'b0;
    p.rxq.delete();
    n = stops;
    @(negedge sys_clk);
    cfg.address_buffer_bypass = 1'b0;
    pulse(2, 8'h02);
    pulse(1, 8'h91);
    repeat (40) @(posedge bus_clk);
    check(status.master_active_flag, 1'b0);
    pulse(6, 8'h00);
    wait_stop(n);
    check(8'(p.rxq.size()), 8'h01);
    check(status.received_ack_status, 1'b1);
    $display("test master nack done");
    ack_en = 1'b1;
    n = stops;
    pulse(2, 8'h02);
    pulse(1, 8'h66);
    pulse(6, 8'h00);
    for (int i = 0; i < 3000 && p.bits != 3; i++) @(posedge bus_clk);
    @(negedge scl_w);
    hold_scl = 1'b1;
    repeat (20) @(posedge bus_clk);
    pulse(5, 8'h02);
    repeat (30) @(posedge sys_clk);
    check(timeout_event_flag, 1'b1);
    check(status.master_active_flag, 1'b1);
    check(8'(stops - n), 8'h00);
    @(negedge sys_clk);
    hold_scl = 1'b0;
    wait_stop(n);
    check(8'(stops - n), 8'h01);
    check(status.master_active_flag, 1'b0);
    $display("test master timeout done");
    end_sim();
  end
endmodule // i2c_bus_conditions_ack_timeout_test
`default_nettype wire
